// File: core/i2c_trig_defines.svh
// constants of the two-wire trigger matcher
`ifndef I2C_TRIG_DEFINES_SVH
`define I2C_TRIG_DEFINES_SVH

// source codes 0..3 are analog channels, 4..19 digital lines
`define ANALOG_SRC_COUNT  5'h04
// bit 8 set in a 9-bit byte compare value (256) means don't care
`define BYTE_DC_BIT       8
// address don't-care codes
`define ADDR7_DC          11'h080
`define ADDR10_DC         11'h400
// first five bits of a long-address first byte
`define TENBIT_PREFIX     5'h1E
// bit counter value of the acknowledge slot
`define ACK_SLOT          4'h8
// byte index saturates here
`define BYTE_IDX_MAX      5'h1F
// reset value of every state flip-flop
`define STATE_RESET       '0

`endif

// File: core/i2c_trig_pkg.sv
// types of the two-wire trigger matcher
`default_nettype none
package i2c_trig_pkg;

	// match conditions
	typedef enum logic [2:0] {
		cond_start          = 3'h0,
		cond_stop           = 3'h1,
		cond_restart        = 3'h2,
		missing_ack_event   = 3'h3,
		cond_ctrl_byte      = 3'h4,
		short_address_frame = 3'h5,
		long_address_frame  = 3'h6,
		length_search_mode  = 3'h7
	} cond_e;

	// byte relation for control-byte frames
	typedef enum logic [1:0] {
		rel_equal = 2'h0,
		rel_more  = 2'h1,
		rel_less  = 2'h2
	} rel_e;

	// direction bit qualifier
	typedef enum logic [1:0] {
		dir_read   = 2'h0,
		dir_write  = 2'h1,
		dir_either = 2'h2
	} dir_e;

	// frame decoder state
	typedef enum logic {
		st_idle = 1'b0,
		st_bits = 1'b1
	} st_e;

	// line source selection, used in the link domain
	typedef struct packed {
		logic [4:0] clock_line_source_cfg;
		logic [7:0] clock_threshold;
		logic [4:0] data_line_source_cfg;
		logic [7:0] data_threshold;
	} line_cfg_s;

	// full host configuration
	typedef struct packed {
		logic        trigger_type_select;
		line_cfg_s   lines;
		cond_e       match_condition_select;
		logic [10:0] address_compare_value;
		logic [8:0]  first_byte_compare_value;
		logic [8:0]  second_byte_compare_value;
		rel_e        byte_relation_select;
		dir_e        direction_qualifier;
		logic        address_width_select;
		logic [3:0]  byte_count_select;
	} cfg_s;

	// state of the link-side front end
	typedef struct packed {
		line_cfg_s        cfg;
		logic [2:0]       req_sync;
		logic [1:0][15:0] dig_sync;
		logic             ack;
		logic             scl;
		logic             sda;
	} front_s;

	// state of the matcher core
	typedef struct packed {
		cfg_s       cfg;
		line_cfg_s  snap;
		logic       req;
		logic [1:0] ack_sync;
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic       scl_prev;
		logic       sda_prev;
		st_e        st;
		logic       busy;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [4:0] byte_idx;
		logic       alive;
		logic       tenbit;
		logic       rw;
		logic [1:0] addr_hi;
		logic       trig;
	} core_s;

endpackage
`default_nettype wire

// File: core/link_if.sv
// carrier between matcher core and link-side front end
`timescale 1ns/1ps
`default_nettype none
interface link_if;
	i2c_trig_pkg::line_cfg_s snap;    // config snapshot, stable while req pending
	logic                    req;     // toggle: new snapshot offered
	logic                    ack;     // toggle: snapshot taken (link clock)
	logic                    scl_lvl; // clock line level (link clock)
	logic                    sda_lvl; // data line level (link clock)
	modport core (output snap, output req, input ack, input scl_lvl, input sda_lvl);
	modport front (input snap, input req, output ack, output scl_lvl, output sda_lvl);
endinterface
`default_nettype wire

// File: core/line_front.sv
// link-side front end: source select and threshold compare
`timescale 1ns/1ps
`default_nettype none
`include "i2c_trig_defines.svh"
module line_front (
	// link clock and reset
	input  wire logic        i_link_clk,
	input  wire logic        i_resetn,
	// acquisition samples
	input  wire logic [31:0] i_analog_code,
	input  wire logic [15:0] i_digital_lines,
	// core side
	link_if.front            lk
);
	i2c_trig_pkg::front_s f_ff;  // registered state
	i2c_trig_pkg::front_s nxt_f; // next state
	logic                 take;  // snapshot toggle seen

	// level of one source: analog compare or digital line
	function automatic logic pick(input logic [4:0] src, input logic [7:0] thr,
		input logic [31:0] an, input logic [15:0] dg);
		logic [4:0] di;
		di = src - `ANALOG_SRC_COUNT;
		if (src < `ANALOG_SRC_COUNT) begin
			pick = (an[{src[1:0], 3'b000} +: 8] >= thr); // R3
		end else begin
			pick = dg[di[3:0]];
		end
	endfunction

	// edge of the synchronised request toggle
	assign take = f_ff.req_sync[1] ^ f_ff.req_sync[2];

	// next state
	always_comb begin
		nxt_f = f_ff;
		nxt_f.req_sync = {f_ff.req_sync[1:0], lk.req};
		// digital pins pass two flops first
		nxt_f.dig_sync = {f_ff.dig_sync[0], i_digital_lines};
		// snapshot is stable while the toggle is pending
		if (take) begin
			nxt_f.cfg = lk.snap;
			nxt_f.ack = f_ff.req_sync[1];
		end
		nxt_f.scl = pick(f_ff.cfg.clock_line_source_cfg, f_ff.cfg.clock_threshold,
			i_analog_code, f_ff.dig_sync[1]); // R1
		nxt_f.sda = pick(f_ff.cfg.data_line_source_cfg, f_ff.cfg.data_threshold,
			i_analog_code, f_ff.dig_sync[1]); // R2
	end

	// link clock registers
	always_ff @(posedge i_link_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			f_ff <= `STATE_RESET;
		end else begin
			f_ff <= nxt_f;
		end
	end

	assign lk.ack     = f_ff.ack;
	assign lk.scl_lvl = f_ff.scl;
	assign lk.sda_lvl = f_ff.sda;

	// a seen toggle loads the offered snapshot
	snap_capture_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn) // R1
		take |=> (f_ff.cfg == $past(lk.snap)) && (f_ff.ack == $past(f_ff.req_sync[1])))
		else $error("line source snapshot not taken");
	// the clock line follows its selected digital source
	clk_source_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn) // R1
		(!take && f_ff.cfg.clock_line_source_cfg == 5'h09) |=> (f_ff.scl == $past(f_ff.dig_sync[1][5])))
		else $error("clock line does not follow its source");
endmodule
`default_nettype wire

// File: core/i2c_bus_trigger_matcher.sv
// two-wire bus trigger matcher: event decode, frame compare, trigger pulse
`timescale 1ns/1ps
`default_nettype none
`include "i2c_trig_defines.svh"
// Contract
// R1: clock line from analog channel or digital line
// R2: data line source chosen independently, same set
// R3: analog source compared against per-line threshold
// R4: trigger on start, stop or missing acknowledge
// R5: repeated start only while transfer open
// R6: control-byte read frame, then compare data byte
// R7: short address frame with two data bytes
// R8: long address frame with two data bytes
// R9: length search on address width, byte count
// R10: one address compare value, address modes
// R11: short mode address 128 matches any
// R12: long mode address 1024 matches any
// R13: first data compare value, 0 to 256
// R14: second data compare, address modes only
// R15: data compare 256 accepts any byte
// R16: settings read back exactly as written
// R17: host selects serial type before criteria
// R18: direction qualifier read, write or either
// R19: control-byte relation equal, more, less
// R20: length search address width 7 or 10
// R21: length search byte count 1 to 12
// R22: synchronise lines; start/stop while clock high
// R23: one-cycle trigger pulse, then rescan
module i2c_bus_trigger_matcher (
	// clocks, reset and enable
	input  wire logic                 i_clk,
	input  wire logic                 i_link_clk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_ce,
	// acquisition samples, link clock domain
	input  wire logic [31:0]          i_analog_code,
	input  wire logic [15:0]          i_digital_lines,
	// host configuration
	input  wire logic                 i_cfg_we,
	input  wire i2c_trig_pkg::cfg_s   i_cfg,
	// results
	output var  i2c_trig_pkg::cfg_s   o_cfg,
	output logic                      o_trigger,
	output logic                      o_bus_open
);
	i2c_trig_pkg::core_s r;        // registered state
	i2c_trig_pkg::core_s n;        // next state
	logic                scl_now;  // synchronised clock line
	logic                sda_now;  // synchronised data line
	logic                start_ev; // start seen this cycle
	logic                stop_ev;  // stop seen this cycle
	logic                scl_rise; // bit sampling edge
	logic                pending;  // snapshot not yet acknowledged
	logic                ten_now;  // first byte carries long prefix
	logic                dir_ok;   // direction bit accepted
	logic                addr7_ok; // short address accepted
	logic                addr10_ok;// long address accepted
	logic [4:0]          abytes;   // address bytes of current frame
	logic [4:0]          dcount;   // data bytes seen so far
	logic                len_hit;  // length search satisfied

	link_if lk ();

	// link-side front end
	line_front u_front (
		.i_link_clk      (i_link_clk),
		.i_resetn        (i_resetn),
		.i_analog_code   (i_analog_code),
		.i_digital_lines (i_digital_lines),
		.lk              (lk)
	);

	// snapshot of the line selection offered to the link domain
	assign lk.snap = r.snap;
	assign lk.req  = r.req;

	// mode selected and serial trigger type active
	function automatic logic mode_is(input i2c_trig_pkg::cfg_s c, input i2c_trig_pkg::cond_e m);
		mode_is = c.trigger_type_select && (c.match_condition_select == m);
	endfunction

	// byte against a 9-bit compare value with a relation
	function automatic logic rel_ok(input i2c_trig_pkg::rel_e rel, input logic [8:0] cmp,
		input logic [7:0] b);
		rel_ok = 1'b1;
		// 256 switches the comparison off
		if (!cmp[`BYTE_DC_BIT]) begin
			if (rel == i2c_trig_pkg::rel_more) begin
				rel_ok = (b > cmp[7:0]);
			end else if (rel == i2c_trig_pkg::rel_less) begin
				rel_ok = (b < cmp[7:0]);
			end else begin
				rel_ok = (b == cmp[7:0]);
			end
		end
	endfunction

	// line events; only the second sync flop and its copy are read
	assign scl_now  = r.scl_sync[1];
	assign sda_now  = r.sda_sync[1];
	assign start_ev = scl_now && r.scl_prev && r.sda_prev && !sda_now; // R22
	assign stop_ev  = scl_now && r.scl_prev && !r.sda_prev && sda_now; // R22
	assign scl_rise = scl_now && !r.scl_prev;
	assign pending  = (r.req != r.ack_sync[1]);

	// first-byte and address qualifiers
	assign ten_now  = (r.shreg[7:3] == `TENBIT_PREFIX);
	assign dir_ok   = (r.cfg.direction_qualifier == i2c_trig_pkg::dir_either) ||
		((r.cfg.direction_qualifier == i2c_trig_pkg::dir_read) && r.shreg[0]) ||
		((r.cfg.direction_qualifier == i2c_trig_pkg::dir_write) && !r.shreg[0]); // R18
	assign addr7_ok = (r.cfg.address_compare_value == `ADDR7_DC) ||
		(r.cfg.address_compare_value == {4'h0, r.shreg[7:1]}); // R10 R11
	assign addr10_ok = (r.cfg.address_compare_value == `ADDR10_DC) ||
		(r.cfg.address_compare_value == {1'b0, r.addr_hi, r.shreg}); // R10 R12

	// length search: width must agree and byte count must equal
	assign abytes  = r.tenbit ? 5'h02 : 5'h01;
	assign dcount  = r.byte_idx - abytes;
	assign len_hit = (r.byte_idx >= abytes) &&
		(r.tenbit == r.cfg.address_width_select) &&
		(dcount == {1'b0, r.cfg.byte_count_select}); // R20 R21

	// next state
	always_comb begin
		n      = r;
		n.trig = 1'b0; // R23
		// settings are kept as written for readback
		if (i_cfg_we) begin
			n.cfg = i_cfg; // R16
		end
		// offer a new snapshot only once the last one was taken
		if (!pending && (r.cfg.lines != r.snap)) begin
			n.snap = r.cfg.lines;
			n.req  = ~r.req;
		end
		n.ack_sync = {r.ack_sync[0], lk.ack};
		// two flops per line across from the link clock
		n.scl_sync = {r.scl_sync[0], lk.scl_lvl}; // R22
		n.sda_sync = {r.sda_sync[0], lk.sda_lvl}; // R22
		n.scl_prev = scl_now;
		n.sda_prev = sda_now;
		if (start_ev) begin
			// a start while open is a repeated start
			if (mode_is(r.cfg, i2c_trig_pkg::cond_start)) begin
				n.trig = 1'b1; // R4
			end else if (mode_is(r.cfg, i2c_trig_pkg::cond_restart) && r.busy) begin
				n.trig = 1'b1; // R5
			end
			n.busy     = 1'b1;
			n.st       = i2c_trig_pkg::st_bits;
			n.bitcnt   = 4'h0;
			n.byte_idx = 5'h00;
			n.alive    = 1'b1;
			n.tenbit   = 1'b0;
		end else if (stop_ev) begin
			if (mode_is(r.cfg, i2c_trig_pkg::cond_stop)) begin
				n.trig = 1'b1; // R4
			end else if (mode_is(r.cfg, i2c_trig_pkg::length_search_mode) && r.busy && len_hit) begin
				n.trig = 1'b1; // R9
			end
			n.busy   = 1'b0;
			n.st     = i2c_trig_pkg::st_idle;
			// the clock rise just before a stop has already counted a bit
			n.bitcnt = 4'h0;
		end else begin
			case (r.st)
				// waiting for a start
				i2c_trig_pkg::st_idle: begin
					n.bitcnt = 4'h0;
				end
				// shifting bits of an open transfer
				i2c_trig_pkg::st_bits: begin
					if (scl_rise && (r.bitcnt != `ACK_SLOT)) begin
						n.shreg  = {r.shreg[6:0], sda_now};
						n.bitcnt = r.bitcnt + 4'h1;
					end else if (scl_rise) begin
						// acknowledge slot closes the byte
						n.bitcnt = 4'h0;
						if (r.byte_idx != `BYTE_IDX_MAX) begin
							n.byte_idx = r.byte_idx + 5'h01;
						end
						if (mode_is(r.cfg, i2c_trig_pkg::missing_ack_event) && sda_now) begin
							n.trig = 1'b1; // R4
						end
						if (r.byte_idx == 5'h00) begin
							n.rw      = r.shreg[0];
							n.tenbit  = ten_now;
							n.addr_hi = r.shreg[2:1];
						end
						case (r.cfg.match_condition_select)
							// control byte must be a read that is acknowledged
							i2c_trig_pkg::cond_ctrl_byte: begin
								if (r.byte_idx == 5'h00) begin
									n.alive = r.alive && r.shreg[0] && !sda_now; // R6
								end else if (r.byte_idx == 5'h01) begin
									if (r.alive && r.cfg.trigger_type_select &&
										rel_ok(r.cfg.byte_relation_select,
										r.cfg.first_byte_compare_value, r.shreg)) begin
										n.trig = 1'b1; // R6 R19 R13
									end
									n.alive = 1'b0;
								end
							end
							// seven-bit address then two data bytes
							i2c_trig_pkg::short_address_frame: begin
								if (r.byte_idx == 5'h00) begin
									n.alive = r.alive && !ten_now && addr7_ok && dir_ok && !sda_now; // R7
								end else if (r.byte_idx == 5'h01) begin
									n.alive = r.alive && rel_ok(i2c_trig_pkg::rel_equal,
										r.cfg.first_byte_compare_value, r.shreg); // R13 R15
								end else if (r.byte_idx == 5'h02) begin
									if (r.alive && r.cfg.trigger_type_select &&
										rel_ok(i2c_trig_pkg::rel_equal,
										r.cfg.second_byte_compare_value, r.shreg)) begin
										n.trig = 1'b1; // R7 R14 R15
									end
									n.alive = 1'b0;
								end
							end
							// ten-bit address over two bytes then two data bytes
							i2c_trig_pkg::long_address_frame: begin
								if (r.byte_idx == 5'h00) begin
									n.alive = r.alive && ten_now && dir_ok && !sda_now; // R8 R18
								end else if (r.byte_idx == 5'h01) begin
									n.alive = r.alive && addr10_ok && !sda_now; // R8
								end else if (r.byte_idx == 5'h02) begin
									n.alive = r.alive && rel_ok(i2c_trig_pkg::rel_equal,
										r.cfg.first_byte_compare_value, r.shreg); // R13 R15
								end else if (r.byte_idx == 5'h03) begin
									if (r.alive && r.cfg.trigger_type_select &&
										rel_ok(i2c_trig_pkg::rel_equal,
										r.cfg.second_byte_compare_value, r.shreg)) begin
										n.trig = 1'b1; // R8 R14 R15
									end
									n.alive = 1'b0;
								end
							end
							// other modes need no per-byte compare
							default: begin
								n.alive = r.alive;
							end
						endcase
					end
				end
				default: begin
					n.st = i2c_trig_pkg::st_idle;
				end
			endcase
		end
	end

	// state register; a low enable freezes everything here
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= `STATE_RESET;
		end else if (i_ce) begin
			r <= n;
		end
	end

	// outputs straight from flip-flops
	assign o_cfg      = r.cfg;
	assign o_trigger  = r.trig;
	assign o_bus_open = r.busy;

	// trigger lasts exactly one enabled cycle
	trig_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R23
		(o_trigger && i_ce) |=> !o_trigger)
		else $error("trigger longer than one cycle");
	// start mode fires on the cycle after a start
	start_trig_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
		(i_ce && start_ev && mode_is(r.cfg, i2c_trig_pkg::cond_start)) |=> o_trigger)
		else $error("start not triggered");
	// stop mode fires on the cycle after a stop
	stop_trig_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
		(i_ce && stop_ev && mode_is(r.cfg, i2c_trig_pkg::cond_stop)) |=> o_trigger)
		else $error("stop not triggered");
	// a start on a closed bus is no repeated start
	restart_open_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
		(i_ce && start_ev && !r.busy && mode_is(r.cfg, i2c_trig_pkg::cond_restart)) |=> !o_trigger)
		else $error("repeated start fired on idle bus");
	// high data in the acknowledge slot fires missing-ack mode
	nak_trig_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
		(i_ce && !start_ev && !stop_ev && scl_rise && r.st == i2c_trig_pkg::st_bits &&
		r.bitcnt == `ACK_SLOT && sda_now &&
		mode_is(r.cfg, i2c_trig_pkg::missing_ack_event)) |=> o_trigger)
		else $error("missing acknowledge not triggered");
	// a write is read back unchanged
	cfg_readback_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R16
		(i_ce && i_cfg_we) |=> (o_cfg == $past(i_cfg)))
		else $error("setting not read back as written");
	// start opens and stop closes the transfer
	open_close_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R22
		(i_ce && (start_ev || stop_ev)) |=> (o_bus_open == $past(start_ev)) && (r.bitcnt == 4'h0))
		else $error("transfer state wrong after start or stop");
	// length search fires at stop when count and width agree
	len_trig_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
		(i_ce && stop_ev && r.busy && len_hit &&
		mode_is(r.cfg, i2c_trig_pkg::length_search_mode)) |=> o_trigger)
		else $error("length search not triggered");
	// bit counter never passes the acknowledge slot
	bit_bound_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R22
		r.bitcnt <= `ACK_SLOT)
		else $error("bit counter out of range");
endmodule
`default_nettype wire

// File: verif/bus_lines_model.sv
// far-side model: two-wire bus lines as they reach the acquisition inputs
`timescale 1ns/1ps
`default_nettype none
module bus_lines_model (
	// acquisition clock
	input  wire logic        i_link_clk,
	// wanted bus levels, pulled up when idle
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	// acquisition samples
	output logic      [31:0] o_analog_code,
	output logic      [15:0] o_digital_lines
);
	logic [7:0] noise_ff; // moving pattern on every unused input

	// defined samples from time zero on
	initial begin
		noise_ff        = 8'h00;
		o_analog_code   = 32'h0000_0000;
		o_digital_lines = 16'hFFFF;
	end

	// clock line on channel 0 and line 5, data line on channel 3 and line 12;
	// the rest keeps changing so that a wrong source choice cannot pass unseen
	always @(posedge i_link_clk) begin
		logic [15:0] d;
		d                    = {noise_ff, ~noise_ff};
		d[5]                 = i_scl;
		d[12]                = i_sda;
		noise_ff            <= noise_ff + 8'h35;
		o_analog_code[7:0]   <= i_scl ? 8'hC0 : 8'h30;
		o_analog_code[23:8]  <= {~noise_ff, noise_ff};
		o_analog_code[31:24] <= i_sda ? 8'hC0 : 8'h30;
		o_digital_lines      <= d;
	end
endmodule
`default_nettype wire

// File: verif/i2c_bus_trigger_matcher_tb.sv
// self-checking bench of the two-wire bus trigger matcher
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_trigger_matcher_tb;
	// one table row: settings, frame shape, expected pulse count
	typedef struct packed {
		logic [2:0]  m;
		logic [10:0] a;
		logic [8:0]  d1;
		logic [8:0]  d2;
		logic [1:0]  r;
		logic [1:0]  dr;
		logic        al;
		logic [3:0]  dl;
		logic [3:0]  n;     // bytes in the frame
		logic [3:0]  nak;   // bytes 0..3 left unacknowledged
		logic        rs;    // repeated start before the stop
		logic [31:0] bytes; // first four bytes, byte 0 on top
		logic [1:0]  exp;
	} row_s;

	logic               clk;         // core clock
	logic               link_clk;    // acquisition clock
	logic               resetn;      // active low reset
	logic               ce;          // core clock enable
	logic               cfg_we;      // settings write strobe
	i2c_trig_pkg::cfg_s cfg;         // settings driven
	i2c_trig_pkg::cfg_s cfg_rb;      // settings read back
	i2c_trig_pkg::cfg_s c;           // settings last written
	logic               trigger;     // trigger pulse
	logic               bus_open;    // transfer open level
	logic               scl;         // wanted clock line level
	logic               sda;         // wanted data line level
	logic [31:0]        analog;      // channel codes
	logic [15:0]        digital;     // digital lines
	int unsigned        trig_cnt;    // pulses seen so far
	int unsigned        base;        // count before a frame
	int                 bad_count;   // mismatches
	int                 comparisons; // checks made

	// ordinary cases: m,a,d1,d2,rel,dir,alen,dlen,n,nak,rs,bytes,exp
	row_s rows [23] = '{
		'{3'h0,11'h000,9'h000,9'h000,2'h0,2'h2,1'b0,4'h0,4'h1,4'h0,1'b1,32'hA0000000,2'h2},
		'{3'h1,11'h000,9'h000,9'h000,2'h0,2'h2,1'b0,4'h0,4'h1,4'h0,1'b0,32'hA0000000,2'h1},
		'{3'h2,11'h000,9'h000,9'h000,2'h0,2'h2,1'b0,4'h0,4'h1,4'h0,1'b1,32'hA0000000,2'h1},
		'{3'h2,11'h000,9'h000,9'h000,2'h0,2'h2,1'b0,4'h0,4'h1,4'h0,1'b0,32'hA0000000,2'h0},
		'{3'h3,11'h000,9'h000,9'h000,2'h0,2'h2,1'b0,4'h0,4'h2,4'h2,1'b0,32'hA0550000,2'h1},
		'{3'h4,11'h000,9'h040,9'h0FF,2'h0,2'h2,1'b0,4'h0,4'h2,4'h0,1'b0,32'hA1400000,2'h1},
		'{3'h4,11'h000,9'h03F,9'h000,2'h1,2'h2,1'b0,4'h0,4'h2,4'h0,1'b0,32'hA1400000,2'h1},
		'{3'h4,11'h000,9'h03F,9'h000,2'h2,2'h2,1'b0,4'h0,4'h2,4'h0,1'b0,32'hA1400000,2'h0},
		'{3'h4,11'h000,9'h040,9'h000,2'h0,2'h2,1'b0,4'h0,4'h2,4'h0,1'b0,32'hA0400000,2'h0},
		'{3'h4,11'h000,9'h100,9'h000,2'h0,2'h2,1'b0,4'h0,4'h2,4'h0,1'b0,32'hA1770000,2'h1},
		'{3'h5,11'h050,9'h011,9'h022,2'h0,2'h1,1'b0,4'h0,4'h3,4'h0,1'b0,32'hA0112200,2'h1},
		'{3'h5,11'h051,9'h011,9'h022,2'h0,2'h1,1'b0,4'h0,4'h3,4'h0,1'b0,32'hA0112200,2'h0},
		'{3'h5,11'h080,9'h011,9'h022,2'h0,2'h0,1'b0,4'h0,4'h3,4'h0,1'b0,32'hA7112200,2'h1},
		'{3'h5,11'h050,9'h011,9'h100,2'h0,2'h2,1'b0,4'h0,4'h3,4'h0,1'b0,32'hA0119900,2'h1},
		'{3'h5,11'h050,9'h012,9'h022,2'h0,2'h2,1'b0,4'h0,4'h3,4'h0,1'b0,32'hA0112200,2'h0},
		'{3'h5,11'h050,9'h011,9'h022,2'h0,2'h0,1'b0,4'h0,4'h3,4'h0,1'b0,32'hA0112200,2'h0},
		'{3'h6,11'h122,9'h011,9'h033,2'h0,2'h1,1'b0,4'h0,4'h4,4'h0,1'b0,32'hF2221133,2'h1},
		'{3'h6,11'h400,9'h011,9'h033,2'h0,2'h1,1'b0,4'h0,4'h4,4'h0,1'b0,32'hF6051133,2'h1},
		'{3'h6,11'h123,9'h011,9'h033,2'h0,2'h1,1'b0,4'h0,4'h4,4'h0,1'b0,32'hF2221133,2'h0},
		'{3'h7,11'h3FF,9'h000,9'h000,2'h0,2'h2,1'b0,4'h2,4'h3,4'h0,1'b0,32'hA0112200,2'h1},
		'{3'h7,11'h000,9'h000,9'h000,2'h0,2'h2,1'b0,4'h3,4'h3,4'h0,1'b0,32'hA0112200,2'h0},
		'{3'h7,11'h000,9'h000,9'h000,2'h0,2'h2,1'b1,4'h2,4'h4,4'h0,1'b0,32'hF2221133,2'h1},
		'{3'h7,11'h000,9'h000,9'h000,2'h0,2'h2,1'b0,4'hC,4'hD,4'h0,1'b0,32'hA0112233,2'h1}
	};

	// device under test
	i2c_bus_trigger_matcher i2c_bus_trigger_matcher_i (
		.i_clk           (clk),
		.i_link_clk      (link_clk),
		.i_resetn        (resetn),
		.i_ce            (ce),
		.i_analog_code   (analog),
		.i_digital_lines (digital),
		.i_cfg_we        (cfg_we),
		.i_cfg           (cfg),
		.o_cfg           (cfg_rb),
		.o_trigger       (trigger),
		.o_bus_open      (bus_open)
	);

	// far side bus lines
	bus_lines_model bus_lines_model_i (
		.i_link_clk      (link_clk),
		.i_scl           (scl),
		.i_sda           (sda),
		.o_analog_code   (analog),
		.o_digital_lines (digital)
	);

	// clocks of unrelated periods
	always #25 clk = ~clk;
	always #32 link_clk = ~link_clk;

	// every high cycle counts, so a stretched pulse shows as a surplus
	always @(posedge clk) begin
		if (trigger === 1'b1) begin
			trig_cnt <= trig_cnt + 1;
		end
	end

	// compare and count
	task automatic check(input logic [67:0] got, input logic [67:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic conclude;
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// settings word from a row, lines on digital inputs 5 and 12
	function automatic i2c_trig_pkg::cfg_s mk(input row_s r);
		i2c_trig_pkg::cfg_s k;
		k                           = '0;
		k.trigger_type_select       = 1'b1;
		k.lines                     = {5'h09, 8'h80, 5'h10, 8'h80};
		k.match_condition_select    = i2c_trig_pkg::cond_e'(r.m);
		k.address_compare_value     = r.a;
		k.first_byte_compare_value  = r.d1;
		k.second_byte_compare_value = r.d2;
		k.byte_relation_select      = i2c_trig_pkg::rel_e'(r.r);
		k.direction_qualifier       = i2c_trig_pkg::dir_e'(r.dr);
		k.address_width_select      = r.al;
		k.byte_count_select         = r.dl;
		return k;
	endfunction

	// one bus phase, held four core cycles
	task automatic ph(input logic cl, input logic da);
		@(posedge clk);
		scl <= cl;
		sda <= da;
		repeat (3) @(posedge clk);
	endtask

	// data only moves while the clock is low, so no false start or stop
	task automatic start_c;
		ph(1'b0, sda);
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
	endtask

	task automatic stop_c;
		ph(1'b0, sda);
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask

	// eight bits msb first, then the acknowledge slot
	task automatic send_byte(input logic [7:0] b, input logic ack);
		logic [8:0] w;
		w = {b, ~ack};
		for (int i = 8; i >= 0; i--) begin
			ph(1'b0, sda);
			ph(1'b0, w[i]);
			ph(1'b1, w[i]);
		end
	endtask

	// write settings, read them back, run one frame, count pulses
	task automatic run(input i2c_trig_pkg::cfg_s k, input row_s r, input logic [1:0] exp);
		@(posedge clk);
		cfg    <= k;
		cfg_we <= 1'b1;
		@(posedge clk);
		cfg_we <= 1'b0;
		c = k;
		@(negedge clk);
		@(negedge clk);
		check(cfg_rb, k);
		repeat (12) @(posedge clk);
		base = trig_cnt;
		start_c();
		for (int j = 0; j < r.n; j++)
			send_byte(j < 4 ? r.bytes[31 - 8 * j -: 8] : 8'h5A, ~(j < 4 && r.nak[j]));
		if (r.rs)
			start_c();
		stop_c();
		repeat (12) @(posedge clk);
		check(68'(trig_cnt - base), 68'(exp));
	endtask

	// main sequence
	initial begin
		clk         = 1'b0;
		link_clk    = 1'b0;
		resetn      = 1'b0;
		ce          = 1'b1;
		cfg_we      = 1'b0;
		cfg         = '0;
		c           = '0;
		scl         = 1'b1;
		sda         = 1'b1;
		trig_cnt    = 0;
		bad_count   = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (20) @(posedge clk);
		for (int i = 0; i < 23; i++)
			run(mk(rows[i]), rows[i], rows[i].exp);
		// analog clock exactly at threshold counts as high
		c = mk(rows[0]);
		c.lines = {5'h00, 8'hC0, 5'h10, 8'h80};
		run(c, rows[0], 2'h2);
		c.lines = {5'h00, 8'hC0, 5'h03, 8'hC0};
		run(c, rows[0], 2'h2);
		// one code above the high level: clock never high, nothing seen
		c.lines.clock_threshold = 8'hC1;
		run(c, rows[0], 2'h0);
		// serial trigger not selected
		c = mk(rows[0]);
		c.trigger_type_select = 1'b0;
		run(c, rows[0], 2'h0);
		// a write while the core is frozen is ignored
		@(posedge clk);
		ce     <= 1'b0;
		cfg_we <= 1'b1;
		cfg    <= ~c;
		repeat (3) @(posedge clk);
		ce     <= 1'b1;
		cfg_we <= 1'b0;
		@(negedge clk);
		check(cfg_rb, c);
		// reset in mid-run clears settings, then matching resumes
		@(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		check(cfg_rb, 68'h0);
		check(68'(trigger), 68'h0);
		resetn <= 1'b1;
		repeat (20) @(posedge clk);
		run(mk(rows[0]), rows[0], 2'h2);
		conclude();
	end

	// the run needs about 10000 cycles; 40000 cycles means a hang
	initial begin
		#2000000;
		bad_count++;
		conclude();
	end
endmodule
`default_nettype wire
